// file: verilog/uef_pkg.sv
package uef_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int DATA_W      = 8;
    localparam int FIFO_WIDTH  = 8;
    localparam int FIFO_DEPTH  = 16;
    localparam int SYNC_STAGES = 3;
    localparam int ADDR_W      = 4;
    localparam int XCHAR_NUM   = 4;

    // ************************************************************
    // Register indices on the host port
    // ************************************************************
    localparam logic [3:0] IDX_EFR     = 4'h0;
    localparam logic [3:0] IDX_IER     = 4'h1;
    localparam logic [3:0] IDX_ISR     = 4'h2;
    localparam logic [3:0] IDX_FCR     = 4'h3;
    localparam logic [3:0] IDX_MCR     = 4'h4;
    localparam logic [3:0] IDX_RESUME1 = 4'h5;
    localparam logic [3:0] IDX_PAUSE2  = 4'h8;

    // Flow character slots, offset from IDX_RESUME1
    localparam logic [1:0] X_RESUME1 = 2'h0;
    localparam logic [1:0] X_RESUME2 = 2'h1;
    localparam logic [1:0] X_PAUSE1  = 2'h2;
    localparam logic [1:0] X_PAUSE2  = 2'h3;

    // ************************************************************
    // Reset values, field positions and gated bits
    // ************************************************************
    localparam logic [7:0] EFR_RESET    = 8'h00;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] IER_ENH_MASK = 8'hF0;
    localparam logic [7:0] ISR_ENH_MASK = 8'h30;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
    localparam int         ISR_SPECIAL  = 4;
    localparam int         MCR_RTS      = 1;

    localparam logic [1:0] SEL_NONE   = 2'h0;
    localparam logic [1:0] SEL_SECOND = 2'h1;
    localparam logic [1:0] SEL_FIRST  = 2'h2;
    localparam logic [1:0] SEL_BOTH   = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       auto_cts;
        logic       auto_rts;
        logic       special_det;
        logic       enh_write;
        logic [1:0] tx_sel;
        logic [1:0] rx_sel;
    } uef_efr_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } uef_host_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } uef_char_t;

    typedef enum logic {TX_IDLE, TX_BUSY} uef_tx_state_t;

endpackage

// file: verilog/uef_pin_sync.sv
`timescale 1ns/100ps
module uef_pin_sync
    import uef_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);

    logic [SYNC_STAGES-1:0] stage;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
        end else begin
            stage <= {stage[SYNC_STAGES-2:0], pin};
        end
    end

    // Only accept a change once the two late stages agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            level <= stage[2];
        end
    end

endmodule

// file: verilog/uef_fifo.sv
`timescale 1ns/100ps
module uef_fifo
    import uef_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count    <= '0;
            in_ready <= 1'b0;
            wr_ptr   <= '0;
            rd_ptr   <= '0;
        end else begin
            count    <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

// file: verilog/uef_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Auto clear-to-send on: pin high stops transmit, pin low lets it resume.
// - Auto request-to-send: flag at trigger level, pin high at trigger plus one.
// - Auto request-to-send: pin returns low once level falls below trigger minus one.
// - Hardware flow off: request-to-send pin follows the inverted modem control bit only.
// - Special detect: match on second pause char still stores it, sets status bit 4.
// - Flow character bit 0 compares with received character bit 0.
// - Enhanced write bit gates upper interrupt, status, FIFO and modem bits.
// - Enhanced feature register is all zero after reset.
// - Dual-character modes send the pair as two sequential characters; receive matches it so only when both selects are dual.
// - Low four enhanced feature bits choose software flow for transmit and receive.
// - Bits 3:2 pick transmitted pair; bits 1:0 pick received comparison.
module uef_top
    import uef_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire uef_host_req_t       host_req,
    output logic        [DATA_W-1:0] host_rdata,
    input  wire logic                clear_to_send_pin_per_channel,
    output logic                     request_to_send_pin,
    input  wire logic        [7:0]   rx_fifo_level,
    input  wire logic        [7:0]   rx_trig_level,
    output logic                     rx_trig_flag,
    input  wire uef_char_t           rx_in,
    output uef_char_t                rx_store,
    input  wire logic        [DATA_W-1:0] tx_in_data,
    input  wire logic                tx_in_valid,
    output logic                     tx_in_ready,
    output uef_char_t                tx_out,
    input  wire logic                tx_done,
    input  wire logic                send_pause_req,
    input  wire logic                send_resume_req,
    output logic                     remote_paused
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ************************************************************
    // Host registers
    // ************************************************************
    uef_efr_t          enhanced_feature_control;
    logic [7:0]        interrupt_enable_reg;
    logic [7:0]        interrupt_status_reg;
    logic [7:0]        fifo_control_reg;
    logic [7:0]        modem_control_reg;
    logic [7:0]        xchar [XCHAR_NUM];
    logic              special_hit;
    logic [3:0]        xidx;

    function automatic logic [7:0] gated_write(input logic [7:0] old_v, input logic [7:0] new_v,
                                               input logic [7:0] mask, input logic en);
        gated_write = en ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction

    function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b);
        char_eq = (a == b);
    endfunction

    assign xidx = host_req.addr - IDX_RESUME1;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enhanced_feature_control <= EFR_RESET;
        end else if (host_req.wr && host_req.addr == IDX_EFR) begin
            enhanced_feature_control <= host_req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_enable_reg <= REG_RESET;
            fifo_control_reg <= REG_RESET;
            modem_control_reg <= REG_RESET;
        end else if (host_req.wr) begin
            if (host_req.addr == IDX_IER) begin
                interrupt_enable_reg <= gated_write(interrupt_enable_reg, host_req.wdata, IER_ENH_MASK, enhanced_feature_control.enh_write);
            end else if (host_req.addr == IDX_FCR) begin
                fifo_control_reg <= gated_write(fifo_control_reg, host_req.wdata, FCR_ENH_MASK, enhanced_feature_control.enh_write);
            end else if (host_req.addr == IDX_MCR) begin
                modem_control_reg <= gated_write(modem_control_reg, host_req.wdata, MCR_ENH_MASK, enhanced_feature_control.enh_write);
            end
        end
    end

    // Only the enhanced status bits are held here; a detection wins over a write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_status_reg <= REG_RESET;
        end else begin
            if (host_req.wr && host_req.addr == IDX_ISR && enhanced_feature_control.enh_write) begin
                interrupt_status_reg <= host_req.wdata & ISR_ENH_MASK;
            end
            if (special_hit) begin
                interrupt_status_reg[ISR_SPECIAL] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < XCHAR_NUM; i++) begin
                xchar[i] <= REG_RESET;
            end
        end else if (host_req.wr && host_req.addr >= IDX_RESUME1 && host_req.addr <= IDX_PAUSE2) begin
            xchar[xidx[1:0]] <= host_req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata <= '0;
        end else if (host_req.addr == IDX_EFR) begin
            host_rdata <= enhanced_feature_control;
        end else if (host_req.addr == IDX_IER) begin
            host_rdata <= interrupt_enable_reg;
        end else if (host_req.addr == IDX_ISR) begin
            host_rdata <= interrupt_status_reg;
        end else if (host_req.addr == IDX_FCR) begin
            host_rdata <= fifo_control_reg;
        end else if (host_req.addr == IDX_MCR) begin
            host_rdata <= modem_control_reg;
        end else if (host_req.addr >= IDX_RESUME1 && host_req.addr <= IDX_PAUSE2) begin
            host_rdata <= xchar[xidx[1:0]];
        end else begin
            host_rdata <= '0;
        end
    end

    // ************************************************************
    // Request-to-send
    // ************************************************************
    logic       rts_stop;
    logic       next_rts_stop;
    logic [8:0] lvl9;
    logic [8:0] trig9;

    assign lvl9  = {1'b0, rx_fifo_level};
    assign trig9 = {1'b0, rx_trig_level};

    always_comb begin
        next_rts_stop = rts_stop;
        if (!enhanced_feature_control.auto_rts) begin
            next_rts_stop = 1'b0;
        end else if (lvl9 >= trig9 + 9'h001) begin
            next_rts_stop = 1'b1;
        end else if (lvl9 + 9'h001 < trig9) begin
            next_rts_stop = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rts_stop            <= 1'b0;
            request_to_send_pin <= 1'b1;
            rx_trig_flag        <= 1'b0;
        end else begin
            rts_stop            <= next_rts_stop;
            request_to_send_pin <= enhanced_feature_control.auto_rts ? next_rts_stop : ~modem_control_reg[MCR_RTS];
            rx_trig_flag        <= enhanced_feature_control.auto_rts && (lvl9 >= trig9);
        end
    end

    // ************************************************************
    // Receive comparison
    // ************************************************************
    logic store_hit;
    logic set_pause;
    logic set_resume;
    logic half_pause;
    logic half_resume;
    logic next_half_pause;
    logic next_half_resume;

    // A lone first character of a pair is swallowed; payload must not contain it
    always_comb begin
        store_hit        = 1'b0;
        special_hit      = 1'b0;
        set_pause        = 1'b0;
        set_resume       = 1'b0;
        next_half_pause  = half_pause;
        next_half_resume = half_resume;
        if (rx_in.valid) begin
            next_half_pause  = 1'b0;
            next_half_resume = 1'b0;
            if (enhanced_feature_control.special_det) begin
                store_hit   = 1'b1;
                special_hit = char_eq(rx_in.data, xchar[X_PAUSE2]);
            end else if (enhanced_feature_control.rx_sel == SEL_FIRST) begin
                set_pause  = char_eq(rx_in.data, xchar[X_PAUSE1]);
                set_resume = char_eq(rx_in.data, xchar[X_RESUME1]);
                store_hit  = !(set_pause || set_resume);
            end else if (enhanced_feature_control.rx_sel == SEL_SECOND) begin
                set_pause  = char_eq(rx_in.data, xchar[X_PAUSE2]);
                set_resume = char_eq(rx_in.data, xchar[X_RESUME2]);
                store_hit  = !(set_pause || set_resume);
            end else if (enhanced_feature_control.rx_sel == SEL_BOTH && enhanced_feature_control.tx_sel == SEL_BOTH) begin
                if (half_pause && char_eq(rx_in.data, xchar[X_PAUSE2])) begin
                    set_pause = 1'b1;
                end else if (half_resume && char_eq(rx_in.data, xchar[X_RESUME2])) begin
                    set_resume = 1'b1;
                end else if (char_eq(rx_in.data, xchar[X_PAUSE1])) begin
                    next_half_pause = 1'b1;
                end else if (char_eq(rx_in.data, xchar[X_RESUME1])) begin
                    next_half_resume = 1'b1;
                end else begin
                    store_hit = 1'b1;
                end
            end else if (enhanced_feature_control.rx_sel == SEL_BOTH) begin
                set_pause  = char_eq(rx_in.data, xchar[X_PAUSE1]) || char_eq(rx_in.data, xchar[X_PAUSE2]);
                set_resume = char_eq(rx_in.data, xchar[X_RESUME1]) || char_eq(rx_in.data, xchar[X_RESUME2]);
                store_hit  = !(set_pause || set_resume);
            end else begin
                store_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_pause    <= 1'b0;
            half_resume   <= 1'b0;
            remote_paused <= 1'b0;
            rx_store      <= '0;
        end else begin
            half_pause    <= next_half_pause;
            half_resume   <= next_half_resume;
            rx_store      <= {store_hit, rx_in.data};
            if (enhanced_feature_control.rx_sel == SEL_NONE || enhanced_feature_control.special_det) begin
                remote_paused <= 1'b0;
            end else if (set_pause) begin
                remote_paused <= 1'b1;
            end else if (set_resume) begin
                remote_paused <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Transmit path
    // ************************************************************
    logic                 cts_level;
    logic                 cts_block;
    logic                 fifo_valid;
    logic                 fifo_ready;
    logic [DATA_W-1:0]    fifo_data;
    uef_tx_state_t        tx_state;
    logic                 flow_pend;
    logic                 flow_kind;
    logic                 flow_step;
    logic                 flow_sending;
    logic                 flow_finish;
    logic [DATA_W-1:0]    flow_char;
    logic                 use_second;

    uef_pin_sync u_cts_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (clear_to_send_pin_per_channel),
        .level   (cts_level)
    );

    uef_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (tx_in_data),
        .in_valid  (tx_in_valid),
        .in_ready  (tx_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    assign cts_block   = enhanced_feature_control.auto_cts && cts_level;
    assign use_second  = flow_step || (enhanced_feature_control.tx_sel == SEL_SECOND);
    assign flow_char   = flow_kind ? xchar[use_second ? X_PAUSE2 : X_PAUSE1]
                                   : xchar[use_second ? X_RESUME2 : X_RESUME1];
    assign flow_finish = (tx_state == TX_BUSY) && tx_done && flow_sending;
    assign fifo_ready  = (tx_state == TX_IDLE) && !cts_block && !flow_pend && !remote_paused;

    // A request that lands on the last character's finishing cycle is kept, not lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flow_pend <= 1'b0;
            flow_kind <= 1'b0;
            flow_step <= 1'b0;
        end else begin
            if (flow_finish) begin
                if (enhanced_feature_control.tx_sel == SEL_BOTH && !flow_step) begin
                    flow_step <= 1'b1;
                end else begin
                    flow_pend <= 1'b0;
                    flow_step <= 1'b0;
                end
            end
            if (enhanced_feature_control.tx_sel != SEL_NONE && (send_pause_req || send_resume_req)
                && (!flow_pend || !flow_sending || (flow_finish && (flow_step || enhanced_feature_control.tx_sel != SEL_BOTH)))) begin
                flow_pend <= 1'b1;
                flow_kind <= send_pause_req;
                flow_step <= 1'b0;
            end
        end
    end

    // Holding off only between characters keeps a started one whole
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state     <= TX_IDLE;
            tx_out       <= '0;
            flow_sending <= 1'b0;
        end else begin
            tx_out.valid <= 1'b0;
            case (tx_state)
                TX_IDLE: begin
                    if (!cts_block && flow_pend) begin
                        tx_out       <= {1'b1, flow_char};
                        flow_sending <= 1'b1;
                        tx_state     <= TX_BUSY;
                    end else if (fifo_valid && fifo_ready) begin
                        tx_out       <= {1'b1, fifo_data};
                        flow_sending <= 1'b0;
                        tx_state     <= TX_BUSY;
                    end
                end
                TX_BUSY: begin
                    if (tx_done) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_cts_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_out.valid |-> $past(!(enhanced_feature_control.auto_cts && cts_level)))
        else $error("character started while clear-to-send held off");
    a_char_whole: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_out.valid |=> !tx_out.valid ##0 (tx_state == TX_BUSY))
        else $error("new character started before the current one ended");
    a_rts_auto_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enhanced_feature_control.auto_rts && (lvl9 >= trig9 + 9'h001) |=> request_to_send_pin && rx_trig_flag)
        else $error("request-to-send not raised above trigger");
    a_rts_auto_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enhanced_feature_control.auto_rts && (lvl9 + 9'h001 < trig9) |=> !request_to_send_pin)
        else $error("request-to-send not released below trigger minus one");
    a_rts_manual: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !enhanced_feature_control.auto_rts |=> request_to_send_pin == !$past(modem_control_reg[MCR_RTS]))
        else $error("request-to-send ignores modem control bit");
    a_special_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_in.valid && enhanced_feature_control.special_det && rx_in.data == xchar[X_PAUSE2]
        |=> rx_store.valid && interrupt_status_reg[ISR_SPECIAL])
        else $error("special character lost or not flagged");
    a_enh_latched: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_req.wr && host_req.addr == IDX_MCR && !enhanced_feature_control.enh_write
        |=> modem_control_reg[7:5] == $past(modem_control_reg[7:5]))
        else $error("latched modem control bits changed");
    a_efr_reset: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> enhanced_feature_control == EFR_RESET)
        else $error("enhanced feature register not cleared by reset");
    a_pair_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_out.valid && flow_sending && enhanced_feature_control.tx_sel == SEL_FIRST && !$past(flow_kind)
        |-> tx_out.data == xchar[X_RESUME1])
        else $error("wrong resume character sent");
    a_rx_discard: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_in.valid && !enhanced_feature_control.special_det && enhanced_feature_control.rx_sel == SEL_FIRST && rx_in.data == xchar[X_PAUSE1]
        |=> !rx_store.valid && remote_paused)
        else $error("pause character not acted on");

endmodule

// file: bench/uef_remote_model.sv
`timescale 1ns/100ps
module uef_remote_model
    import uef_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire uef_char_t tx_out,
    input  wire logic      hold_off,
    output logic           cts_pin,
    output logic           tx_done
);
    logic [3:0] busy_cnt;

    assign cts_pin = hold_off;

    initial begin
        busy_cnt = 4'h0;
        tx_done  = 1'b0;
    end

    // Each character occupies the line a few cycles, so done lags the start
    always @(posedge ref_clk) begin
        tx_done <= (busy_cnt == 4'h1);
        if (tx_out.valid) begin
            busy_cnt <= 4'h5;
        end else if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
        end
    end
endmodule

// file: bench/uef_top_test.sv
`timescale 1ns/100ps
module uef_top_test;
    import uef_pkg::*;
    logic ref_clk = 0, rstn = 0, rts, flag, tdone, cts, hold = 0, rdy, paused;
    logic [7:0] rdata, lvl = 8'h00, trig = 8'h06, tdata = 8'h00;
    logic tvalid = 0;
    logic spreq = 0, srreq = 0;
    uef_host_req_t hreq = '0;
    uef_char_t rxi = '0, rxs, txo;
    int failures = 0, samples_checked = 0;

    always #4 ref_clk = ~ref_clk;

    uef_top DUT (.ref_clk(ref_clk), .rstn(rstn), .host_req(hreq), .host_rdata(rdata),
        .clear_to_send_pin_per_channel(cts), .request_to_send_pin(rts), .rx_fifo_level(lvl),
        .rx_trig_level(trig), .rx_trig_flag(flag), .rx_in(rxi), .rx_store(rxs),
        .tx_in_data(tdata), .tx_in_valid(tvalid), .tx_in_ready(rdy), .tx_out(txo),
        .tx_done(tdone), .send_pause_req(spreq), .send_resume_req(srreq), .remote_paused(paused));
    uef_remote_model peer (.ref_clk(ref_clk), .tx_out(txo), .hold_off(hold), .cts_pin(cts),
        .tx_done(tdone));

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk) hreq <= '{1'b1, a, d};
        @(posedge ref_clk) hreq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk) hreq.addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 chk(rdata, e);
    endtask
    task automatic rx(input logic [7:0] d);
        @(posedge ref_clk) rxi <= '{1'b1, d};
        @(posedge ref_clk) rxi.valid <= 1'b0;
        #1;
    endtask
    // Waits for a start pulse and checks what it carries
    task automatic see_tx(input logic [7:0] e);
        repeat (20) begin
            @(posedge ref_clk);
            #1;
            if (txo.valid) begin
                break;
            end
        end
        chk({txo.valid, txo.data}, {8'h01, e});
    endtask
    // The gap lets any flow character still on the line finish first
    task automatic flow_req(input logic pause);
        repeat (8) @(posedge ref_clk);
        spreq <= pause;
        srreq <= !pause;
        @(posedge ref_clk);
        spreq <= 1'b0;
        srreq <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200000 failures++;
        test_done;
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(IDX_EFR, 8'h00);
        chk(rts, 1'b1);
        chk(rdy, 1'b1);
        wr(IDX_IER, 8'hFF);
        rd(IDX_IER, 8'h0F);
        wr(IDX_EFR, 8'h10);
        wr(IDX_IER, 8'hFF);
        wr(IDX_MCR, 8'hE2);
        wr(IDX_EFR, 8'h00);
        wr(IDX_IER, 8'h00);
        wr(IDX_MCR, 8'h02);
        rd(IDX_IER, 8'hF0);
        rd(IDX_MCR, 8'hE2);
        rd(4'hF, 8'h00);
        chk(rts, 1'b0);
        wr(IDX_EFR, 8'h40);
        lvl <= 8'h07;
        repeat (3) @(posedge ref_clk);
        chk({rts, flag}, 16'h0003);
        lvl <= 8'h04;
        repeat (3) @(posedge ref_clk);
        chk(rts, 1'b0);
        wr(IDX_PAUSE2, 8'h13);
        wr(IDX_EFR, 8'h20);
        rx(8'h13);
        chk({rxs.valid, rxs.data}, 16'h0113);
        rx(8'h12);
        rd(IDX_ISR, 8'h10);
        wr(4'h7, 8'h11);
        wr(IDX_EFR, 8'h02);
        rx(8'h11);
        chk({rxs.valid, paused}, 16'h0001);
        wr(IDX_EFR, 8'h01);
        rx(8'h00);
        chk({rxs.valid, paused}, 16'h0000);
        rx(8'h13);
        chk({rxs.valid, paused}, 16'h0001);
        wr(IDX_EFR, 8'h0F);
        rx(8'h00);
        chk({rxs.valid, paused}, 16'h0001);
        rx(8'h00);
        chk({rxs.valid, paused}, 16'h0000);
        wr(IDX_EFR, 8'h80);
        hold <= 1'b1;
        repeat (6) @(posedge ref_clk);
        tdata <= 8'h41;
        tvalid <= 1'b1;
        @(posedge ref_clk) tvalid <= 1'b0;
        repeat (20) begin
            @(posedge ref_clk);
            #1 chk(txo.valid, 1'b0);
        end
        @(posedge ref_clk) hold <= 1'b0;
        see_tx(8'h41);
        wr(4'h5, 8'h21);
        wr(IDX_EFR, 8'h08);
        flow_req(1'b0);
        see_tx(8'h21);
        flow_req(1'b1);
        see_tx(8'h11);
        test_done;
    end
endmodule
